/* cm_host_ctrl.v */
`timescale 1ns/1ns
`include "cm_defs.vh"

// Operation
// - Master encodes transaction on two mode bits: read, pause-read, word, byte write.
// - Byte write: address bit zero picks high or low byte lanes.
// - After pause-read, master must write the same address; device skips read.
// - Cycle starts on address match, select clear, slave sync clear, master sync.
module cm_host_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [15:0] mem_addr,
    output reg [1:0] mem_mode,
    output reg [15:0] mem_data_out,
    output reg mem_data_oe_n,
    input wire [15:0] mem_data_in,
    output reg mem_msyn,
    input wire mem_ssyn,
    output reg mem_bus_init,
    output reg mem_power_low
);

localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_SETUP = 5'b00010;
localparam [4:0] ST_MSYN = 5'b00100;
localparam [4:0] ST_RELEASE = 5'b01000;
localparam [4:0] ST_INIT = 5'b10000;
localparam integer INIT_CYC = `CM_INIT_CYC;
localparam integer DESKEW_CYC = `CM_DESKEW_CYC;

// Place the byte on the lanes its address selects
function [15:0] lane_route;
    input [1:0] mode;
    input a0;
    input [15:0] d;
    begin
        if (mode == `CM_MODE_BYTE_WR && a0)
            lane_route = {d[7:0], 8'h00};
        else if (mode == `CM_MODE_BYTE_WR)
            lane_route = {8'h00, d[7:0]};
        else
            lane_route = d;
    end
endfunction

reg [4:0] state_ff;
reg [4:0] nxt_state;
reg [7:0] cnt_ff;
reg [7:0] nxt_cnt;
reg [1:0] mode_reg_ff;
reg [15:0] addr_reg_ff;
reg [15:0] wdata_reg_ff;
reg [15:0] rdata_ff;
reg done_ff;
reg pause_pend_ff;
reg [15:0] pause_addr_ff;
reg order_err_ff;
reg ssyn_s1_ff;
reg ssyn_s2_ff;
reg ssyn_s3_ff;
reg ssyn_ff;
reg [15:0] din_s1_ff;
reg [15:0] din_s2_ff;
reg [15:0] din_s3_ff;
reg [31:0] rd_mux;

wire bus_wr = psel & penable & pready & pwrite;
wire ctrl_wr = bus_wr && paddr == `CM_OFS_CTRL;
wire start_req = ctrl_wr && pwdata[`CM_CTRL_START];
wire init_req = ctrl_wr && pwdata[`CM_CTRL_INIT];
wire [1:0] req_mode = pwdata[`CM_CTRL_MODE_HI:`CM_CTRL_MODE_LO];
wire idle = state_ff == ST_IDLE;
wire req_is_wr = req_mode[1];
// After a pause-read only a write to the same address may follow
wire order_bad = pause_pend_ff &&
    (!req_is_wr || addr_reg_ff != pause_addr_ff);
wire launch = start_req && idle && !order_bad && !init_req;
wire finish = state_ff == ST_RELEASE && !ssyn_ff;
wire known = paddr == `CM_OFS_CTRL || paddr == `CM_OFS_ADDR ||
    paddr == `CM_OFS_WDATA || paddr == `CM_OFS_RDATA ||
    paddr == `CM_OFS_STATUS;

always @*
begin
    rd_mux = 32'h0000_0000;
    case (paddr)
        `CM_OFS_CTRL:
        begin
            rd_mux[`CM_CTRL_MODE_HI:`CM_CTRL_MODE_LO] = mode_reg_ff;
            rd_mux[`CM_CTRL_PWR_LOW] = mem_power_low;
        end
        `CM_OFS_ADDR: rd_mux[15:0] = addr_reg_ff;
        `CM_OFS_WDATA: rd_mux[15:0] = wdata_reg_ff;
        `CM_OFS_RDATA: rd_mux[15:0] = rdata_ff;
        `CM_OFS_STATUS:
        begin
            rd_mux[`CM_ST_BUSY] = !idle;
            rd_mux[`CM_ST_DONE] = done_ff;
            rd_mux[`CM_ST_PAUSE] = pause_pend_ff;
            rd_mux[`CM_ST_ORDER_ERR] = order_err_ff;
            rd_mux[`CM_ST_SSYN] = ssyn_ff;
        end
        default: rd_mux = 32'h0000_0000;
    endcase
end

// One wait state: pready rises in the second access cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= psel & penable & !pready;
        pslverr <= psel & penable & !pready & !known;
        if (psel & penable & !pready & !pwrite)
            prdata <= rd_mux;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mode_reg_ff <= `CM_MODE_READ;
        addr_reg_ff <= `CM_ADDR_RST;
        wdata_reg_ff <= `CM_WDATA_RST;
        mem_power_low <= 1'b0;
        done_ff <= 1'b0;
        order_err_ff <= 1'b0;
    end
    else
    begin
        if (ctrl_wr)
        begin
            mode_reg_ff <= req_mode;
            mem_power_low <= pwdata[`CM_CTRL_PWR_LOW];
        end
        if (bus_wr && paddr == `CM_OFS_ADDR)
            addr_reg_ff <= pwdata[15:0];
        if (bus_wr && paddr == `CM_OFS_WDATA)
            wdata_reg_ff <= pwdata[15:0];
        // Hardware set beats a same-cycle software clear
        if (finish)
            done_ff <= 1'b1;
        else if (bus_wr && paddr == `CM_OFS_STATUS && pwdata[`CM_ST_DONE])
            done_ff <= 1'b0;
        if (start_req && idle && order_bad)
            order_err_ff <= 1'b1;
        else if (bus_wr && paddr == `CM_OFS_STATUS &&
            pwdata[`CM_ST_ORDER_ERR])
            order_err_ff <= 1'b0;
    end
end

// Three-stage sync; a change counts once stages two and three agree
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ssyn_s1_ff <= 1'b0;
        ssyn_s2_ff <= 1'b0;
        ssyn_s3_ff <= 1'b0;
        ssyn_ff <= 1'b0;
        din_s1_ff <= 16'h0000;
        din_s2_ff <= 16'h0000;
        din_s3_ff <= 16'h0000;
    end
    else
    begin
        ssyn_s1_ff <= mem_ssyn;
        ssyn_s2_ff <= ssyn_s1_ff;
        ssyn_s3_ff <= ssyn_s2_ff;
        if (ssyn_s2_ff == ssyn_s3_ff)
            ssyn_ff <= ssyn_s3_ff;
        din_s1_ff <= mem_data_in;
        din_s2_ff <= din_s1_ff;
        din_s3_ff <= din_s2_ff;
    end
end

always @*
begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
        ST_IDLE:
        begin
            if (init_req)
            begin
                nxt_state = ST_INIT;
                nxt_cnt = INIT_CYC[7:0];
            end
            else if (launch)
            begin
                nxt_state = ST_SETUP;
                nxt_cnt = DESKEW_CYC[7:0];
            end
        end
        // Address and mode settle; slave sync must be idle first
        ST_SETUP:
        begin
            if (cnt_ff != 8'h00)
                nxt_cnt = cnt_ff - 8'h01;
            else if (!ssyn_ff)
                nxt_state = ST_MSYN;
        end
        ST_MSYN:
            if (ssyn_ff)
                nxt_state = ST_RELEASE;
        ST_RELEASE:
            if (!ssyn_ff)
                nxt_state = ST_IDLE;
        // Init held long enough for the select-clear delay
        ST_INIT:
        begin
            if (cnt_ff != 8'h00)
                nxt_cnt = cnt_ff - 8'h01;
            else
                nxt_state = ST_IDLE;
        end
        default:
            nxt_state = ST_IDLE;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_ff <= ST_IDLE;
        cnt_ff <= 8'h00;
        mem_addr <= 16'h0000;
        mem_mode <= `CM_MODE_READ;
        mem_data_out <= 16'h0000;
        mem_data_oe_n <= 1'b1;
        mem_msyn <= 1'b0;
        mem_bus_init <= 1'b0;
        rdata_ff <= 16'h0000;
        pause_pend_ff <= 1'b0;
        pause_addr_ff <= 16'h0000;
    end
    else
    begin
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        mem_bus_init <= nxt_state == ST_INIT;
        if (launch)
        begin
            mem_addr <= addr_reg_ff;
            mem_mode <= req_mode;
            mem_data_out <= lane_route(req_mode, addr_reg_ff[0],
                wdata_reg_ff);
            mem_data_oe_n <= !req_is_wr;
        end
        if (state_ff == ST_SETUP && nxt_state == ST_MSYN)
            mem_msyn <= 1'b1;
        if (state_ff == ST_MSYN && ssyn_ff)
        begin
            mem_msyn <= 1'b0;
            if (!mem_mode[1])
                rdata_ff <= din_s3_ff;
        end
        if (finish)
        begin
            mem_data_oe_n <= 1'b1;
            pause_pend_ff <= mem_mode == `CM_MODE_READ_PAUSE;
            pause_addr_ff <= mem_addr;
        end
        if (nxt_state == ST_INIT)
            pause_pend_ff <= 1'b0;
    end
end

endmodule

/* cm_defs.vh */
`ifndef CM_DEFS_VH
`define CM_DEFS_VH

// Register word offsets (byte addresses)
`define CM_OFS_CTRL 8'h00
`define CM_OFS_ADDR 8'h04
`define CM_OFS_WDATA 8'h08
`define CM_OFS_RDATA 8'h0C
`define CM_OFS_STATUS 8'h10

// CTRL fields
`define CM_CTRL_START 0
`define CM_CTRL_MODE_LO 1
`define CM_CTRL_MODE_HI 2
`define CM_CTRL_INIT 3
`define CM_CTRL_PWR_LOW 4

// STATUS fields
`define CM_ST_BUSY 0
`define CM_ST_DONE 1
`define CM_ST_PAUSE 2
`define CM_ST_ORDER_ERR 3
`define CM_ST_SSYN 4

// Mode-control encodings
`define CM_MODE_READ 2'b00
`define CM_MODE_READ_PAUSE 2'b01
`define CM_MODE_WORD_WR 2'b10
`define CM_MODE_BYTE_WR 2'b11

// Reset values
`define CM_CTRL_RST 32'h0000_0000
`define CM_ADDR_RST 16'h0000
`define CM_WDATA_RST 16'h0000

// Timing
`define CM_CLK_MHZ 100
`define CM_INIT_NS 100
`define CM_DESKEW_NS 150
`define CM_INIT_CYC ((`CM_INIT_NS * `CM_CLK_MHZ + 999) / 1000)
`define CM_DESKEW_CYC ((`CM_DESKEW_NS * `CM_CLK_MHZ + 999) / 1000)

`endif

/* cm_host_ctrl_sva.sv */
`timescale 1ns/1ns
module cm_host_ctrl_sva (
    input wire pclk,
    input wire presetn,
    input wire [15:0] mem_addr,
    input wire [1:0] mem_mode,
    input wire [15:0] mem_data_out,
    input wire mem_data_oe_n,
    input wire mem_msyn,
    input wire mem_ssyn,
    input wire mem_bus_init
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_lane_idle: assert property (
        mem_msyn && mem_mode == 2'h3 |-> (mem_addr[0] ?
        mem_data_out[7:0] : mem_data_out[15:8]) == 8'h00)
        else $error("Unused byte lane driven");
    a_data_dir: assert property (
        mem_msyn |-> mem_data_oe_n == !mem_mode[1])
        else $error("Data direction wrong");
    a_init_len: assert property (
        $rose(mem_bus_init) |-> ##10 mem_bus_init ##1 !mem_bus_init)
        else $error("Init pulse length wrong");
    a_init_quiet: assert property (
        mem_bus_init |-> !mem_msyn) else $error("Sync during init");
    a_start_gate: assert property (
        mem_ssyn |=> !$rose(mem_msyn)) else $error("Start while ssyn");
    a_addr_hold: assert property (
        mem_msyn && $past(mem_msyn) |-> $stable({mem_addr, mem_mode}))
        else $error("Address moved in cycle");
    a_sync_hold: assert property (
        mem_msyn && !mem_ssyn |=> mem_msyn) else $error("Sync dropped early");
    a_sync_drop: assert property (
        mem_msyn && mem_ssyn |-> ##[1:6] !mem_msyn)
        else $error("Sync not released");
    cover property (mem_msyn && mem_mode == 2'h1);
    cover property (mem_msyn && mem_mode == 2'h3);
    cover property ($rose(mem_bus_init));
endmodule

bind cm_host_ctrl cm_host_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn),
    .mem_addr(mem_addr), .mem_mode(mem_mode), .mem_data_out(mem_data_out),
    .mem_data_oe_n(mem_data_oe_n), .mem_msyn(mem_msyn),
    .mem_ssyn(mem_ssyn), .mem_bus_init(mem_bus_init));

/* cm_mem_model.sv */
`timescale 1ns/1ns
module cm_mem_model #(
    parameter READ_ONLY_STRAP = 0
) (
    input wire [15:0] mem_addr,
    input wire [1:0] mem_mode,
    input wire [15:0] mem_data_out,
    input wire mem_msyn,
    input wire mem_bus_init,
    input wire slow,
    output reg [15:0] mem_data_in,
    output reg mem_ssyn
);
    reg [15:0] core [0:255];
    reg pause_ff = 1'b0;
    reg memory_select_ff = 1'b0;
    reg delay_start_ff = 1'b0;
    initial
    begin
        mem_ssyn = 1'b0;
        mem_data_in = 16'h5a5a;
    end
    // A start while selected is lost, so a host retrigger stalls the host until the test's poll limit ends the run
    always @(posedge mem_msyn)
    if (!memory_select_ff && !mem_ssyn)
    begin
        memory_select_ff = 1'b1;
        // Delay start is raised on every accepted start
        delay_start_ff = 1'b1;
        // Off the clock edge; when not slow, shorter if the read phase is skipped
        #(slow ? 303 : (pause_ff ? 23 : 33));
        if (READ_ONLY_STRAP || !mem_mode[1])
            mem_data_in = core[mem_addr[8:1]];
        else if (mem_mode[0] && mem_addr[0])
            core[mem_addr[8:1]][15:8] = mem_data_out[15:8];
        else if (mem_mode[0])
            core[mem_addr[8:1]][7:0] = mem_data_out[7:0];
        else
            core[mem_addr[8:1]] = mem_data_out;
        pause_ff = (mem_mode == 2'h1) && !READ_ONLY_STRAP;
        if (pause_ff)
            memory_select_ff = 1'b0;
        mem_ssyn = 1'b1;
    end
    always @(negedge mem_msyn)
    begin
        #23;
        mem_ssyn = 1'b0;
        // Released lines must not keep showing the old word
        mem_data_in = ~mem_data_in;
        delay_start_ff = 1'b0;
        memory_select_ff = 1'b0;
    end
    always @(posedge mem_bus_init)
    begin
        pause_ff = 1'b0;
        delay_start_ff = 1'b0;
        #100;
        memory_select_ff = 1'b0;
    end
endmodule

/* core_memory_bus_slave_control_tb.sv */
`timescale 1ns/1ns
`include "cm_defs.vh"
module core_memory_bus_slave_control_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_6a77, q;
    reg e;
    wire [31:0] prdata;
    wire pready, pslverr, oe_n, msyn, ssyn, binit, plow;
    wire [15:0] maddr, mdo, mdi;
    wire [1:0] mmode;
    integer bad_count = 0, samples_checked = 0, k, n;
    int ref_mem [0:255];
    always #5 pclk = ~pclk;
    cm_host_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(maddr), .mem_mode(mmode), .mem_data_out(mdo),
        .mem_data_oe_n(oe_n), .mem_data_in(mdi), .mem_msyn(msyn),
        .mem_ssyn(ssyn), .mem_bus_init(binit), .mem_power_low(plow));
    cm_mem_model u_mem (.mem_addr(maddr), .mem_mode(mmode),
        .mem_data_out(mdo), .mem_msyn(msyn), .mem_bus_init(binit),
        .slow(slow), .mem_data_in(mdi), .mem_ssyn(ssyn));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task print_verdict;
        begin
            $display("Checked %0d, bad %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("ERROR %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            for (n = 0; n < 16 && pready !== 1'b1; n = n + 1)
                @(posedge pclk);
            if (n == 16)
                chk(32'h0000_0000, 32'h0000_0001);
            if (n == 16)
                print_verdict;
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task op(input [1:0] m, input [15:0] a, input [15:0] d);
        begin
            apb(1, `CM_OFS_ADDR, {16'h0000, a});
            apb(1, `CM_OFS_WDATA, {16'h0000, d});
            apb(1, `CM_OFS_CTRL, {29'h0000_0000, m, 1'b1});
            q = 32'h0000_0000;
            for (k = 0; k < 60 && q[`CM_ST_DONE] !== 1'b1; k = k + 1)
                apb(0, `CM_OFS_STATUS, 32'h0000_0000);
            chk(k < 60, 1);
            if (k == 60)
                print_verdict;
            apb(1, `CM_OFS_STATUS, 32'h0000_0002);
            if (m == 2'h2)
                ref_mem[a[8:1]] = d;
            else if (m == 2'h3 && a[0])
                ref_mem[a[8:1]][15:8] = d[7:0];
            else if (m == 2'h3)
                ref_mem[a[8:1]][7:0] = d[7:0];
            else
                apb(0, `CM_OFS_RDATA, 32'h0000_0000);
            if (!m[1])
                chk(q, ref_mem[a[8:1]]);
        end
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CM_OFS_CTRL, 32'h0000_0000);
        chk(q, `CM_CTRL_RST);
        apb(0, 8'h14, 32'h0000_0000);
        chk({q[30:0], e}, 32'h0000_0001);
        $display("Test reset and decode done");
        repeat (8)
        begin
            seed = lfsr(seed);
            slow = seed[5];
            op(2'h2, seed[15:0], seed[31:16]);
            op(2'h3, seed[15:0], seed[23:8]);
            op(2'h0, seed[15:0], 16'h0000);
            op(2'h1, seed[15:0], 16'h0000);
            op({1'b1, seed[9]}, seed[15:0], seed[31:16]);
            op(2'h0, seed[15:0], 16'h0000);
        end
        $display("Test traffic done");
        op(2'h1, seed[15:0], 16'h0000);
        apb(1, `CM_OFS_CTRL, 32'h0000_0001);
        apb(0, `CM_OFS_STATUS, 32'h0000_0000);
        chk(q[`CM_ST_ORDER_ERR], 1);
        apb(1, `CM_OFS_STATUS, 32'h0000_0008);
        apb(1, `CM_OFS_ADDR, {16'h0000, seed[15:0] ^ 16'h0002});
        apb(1, `CM_OFS_CTRL, 32'h0000_0005);
        apb(0, `CM_OFS_STATUS, 32'h0000_0000);
        chk(q[4:0], 5'h0c);
        apb(1, `CM_OFS_CTRL, 32'h0000_0008);
        // Init pulse lasts a fixed eleven cycles
        repeat (15) @(posedge pclk);
        apb(1, `CM_OFS_STATUS, 32'h0000_0008);
        apb(0, `CM_OFS_STATUS, 32'h0000_0000);
        chk(q[3:2], 0);
        op(2'h0, seed[15:0], 16'h0000);
        apb(1, `CM_OFS_CTRL, 32'h0000_0010);
        @(posedge pclk);
        chk(plow, 1);
        apb(1, `CM_OFS_CTRL, 32'h0000_0000);
        @(posedge pclk);
        chk(plow, 0);
        $display("Test order, init and power done");
        print_verdict;
    end
endmodule
